// [pkg/sscp_map.svh]
// Address map, command codes and field positions of the serial command port.
// Assumes inclusion by any file that needs these numbers; definitions only.
`ifndef SSCP_MAP_SVH
`define SSCP_MAP_SVH

// Fixed upper nibble of the slave address
`define SSCP_DEV_NIBBLE 4'hA

// Volatile register bank window
`define SSCP_REG_FIRST 8'h00
`define SSCP_REG_LAST 8'h13

// Configuration EEPROM window
`define SSCP_EE_FIRST 8'h20
`define SSCP_EE_LAST 8'h33

// Command codes
`define SSCP_CMD_BLK_WR_SEL 8'hC0
`define SSCP_CMD_BLK_RD 8'hC1
`define SSCP_CMD_REBOOT 8'hC4
`define SSCP_CMD_BLK_WR 8'h83

// Block transfer length limit and the count sent on a block read
`define SSCP_BLK_MAX 5'h10
`define SSCP_BLK_RD_COUNT 8'h10

// Configuration lock bit position inside the last register
`define SSCP_LOCK_BIT 0

// Reset values
`define SSCP_MEM_RST 8'h00
`define SSCP_PTR_RST 8'h00

`endif

// [pkg/sscp_pkg.sv]
// Types shared by the serial command port design files.
// Assumes sscp_map.svh holds the numbers; this package holds only types.
package sscp_pkg;

	// Serial bus bit-level states
	typedef enum logic [2:0] {
		st_idle,
		st_rx,
		st_rx_ack,
		st_rx_hold,
		st_tx,
		st_tx_ack,
		st_tx_next
	} sscp_bus_t;

	// Position inside a transaction
	typedef enum logic [2:0] {
		ph_addr,
		ph_cmd,
		ph_data1,
		ph_data2,
		ph_count,
		ph_blkw,
		ph_rd,
		ph_ignore
	} sscp_phase_t;

	// One memory write as seen by the rest of the device
	typedef struct packed {
		logic vld;
		logic [7:0] addr;
		logic [7:0] data;
	} sscp_wr_t;

endpackage : sscp_pkg

// [core/sscp_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes one clock, mclk, and a synchronous active-high reset.
`timescale 1ns/1ps
module sscp_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST = '1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Pin side and synchronised side
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_sync
);

	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta <= RST;
			pin_sync <= RST;
		end else begin
			meta <= pin_in;
			pin_sync <= meta;
		end
	end

endmodule : sscp_sync

// [core/sscp_mem.sv]
// Register bank and configuration EEPROM image behind the serial port.
// Assumes callers present only validated addresses; EEPROM timing is external.
`timescale 1ns/1ps
`include "sscp_map.svh"
module sscp_mem
	import sscp_pkg::*;
#(
	parameter int DEPTH = 20
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Write port from the protocol engine
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	// Read port, combinational on the pointer
	input wire logic [7:0] raddr,
	output logic [7:0] rdata,
	// Device side
	output sscp_wr_t wr_out,
	output logic cfg_locked
);

	logic [7:0] reg_bank [DEPTH];
	logic [7:0] ee_bank [DEPTH];

	// Offset inside whichever window the address falls in
	function automatic logic [4:0] sscp_idx(input logic [7:0] a);
		logic [7:0] off;
		off = (a >= `SSCP_EE_FIRST) ? a - `SSCP_EE_FIRST : a;
		return off[4:0];
	endfunction : sscp_idx

	// Storage; both banks cleared so reads are defined
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				reg_bank[i] <= `SSCP_MEM_RST;
				ee_bank[i] <= `SSCP_MEM_RST;
			end
		end else if (we) begin
			if (waddr >= `SSCP_EE_FIRST)
				ee_bank[sscp_idx(waddr)] <= wdata;
			else
				reg_bank[sscp_idx(waddr)] <= wdata;
		end
	end

	// Registered copy of each write for the supervisory logic
	always_ff @(posedge mclk) begin
		if (reset)
			wr_out <= '0;
		else
			wr_out <= '{vld: we, addr: waddr, data: wdata};
	end

	assign rdata = (raddr >= `SSCP_EE_FIRST) ? ee_bank[sscp_idx(raddr)]
		: reg_bank[sscp_idx(raddr)];
	assign cfg_locked = reg_bank[DEPTH-1][`SSCP_LOCK_BIT];

endmodule : sscp_mem

// [core/sscp_port.sv]
// Two-wire serial slave command port of the supply supervisor.
// Assumes the serial clock is slow against mclk (125 MHz) and the data line
// is open drain with an external pull-up; busy_in covers reboot and EEPROM.
`timescale 1ns/1ps
`include "sscp_map.svh"
module sscp_port
	import sscp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Address straps
	input wire logic addr_strap_high,
	input wire logic addr_strap_low,
	// Device status and actions
	input wire logic busy_in,
	output logic reboot_pulse,
	output sscp_wr_t mem_wr,
	output logic cfg_locked
);

	// Synchronised pins and their previous samples
	logic scl_s, sda_s, strap_hi_s, strap_lo_s;
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	// Bit-level engine
	sscp_bus_t bus_st;
	logic [3:0] bit_cnt;
	logic [7:0] rx_sr;
	logic [7:0] tx_sr;
	logic sda_drv;
	logic ack_q;
	logic go_tx_q;
	logic byte_done;
	logic [7:0] rx_byte;

	// Transaction state
	sscp_phase_t phase;
	logic [7:0] ptr;
	logic [4:0] blk_left;
	logic blk_armed;
	logic blk_rd;
	logic send_cnt;

	// Decisions taken when a received byte completes
	logic ack_dec, go_tx, we, reboot_set, arm_set, arm_clr, ptr_load;
	logic cnt_load, cnt_dec;
	logic [7:0] we_addr, nptr;
	sscp_phase_t nphase;

	// Read path
	logic [7:0] rd_data;
	logic [7:0] tx_byte;
	logic master_ack, rd_last;

	// Valid target of a write or pointer preset
	function automatic logic sscp_valid(input logic [7:0] a);
		return (a <= `SSCP_REG_LAST) ||
			(a >= `SSCP_EE_FIRST && a <= `SSCP_EE_LAST);
	endfunction : sscp_valid

	// Pointer step that stops at the end of either window
	function automatic logic [7:0] sscp_next(input logic [7:0] a);
		if (a == `SSCP_REG_LAST || a == `SSCP_EE_LAST)
			return a;
		return a + 8'h01;
	endfunction : sscp_next

	// Lock leaves only the lock-holding locations writable, so it can be undone
	function automatic logic sscp_wr_ok(input logic [7:0] a, input logic lk);
		return !lk || a == `SSCP_REG_LAST || a == `SSCP_EE_LAST;
	endfunction : sscp_wr_ok

	// Pins come from the bus clock domain
	sscp_sync #(
		.W(4),
		.RST(4'hF)
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.pin_in({scl_in, sda_in, addr_strap_high, addr_strap_low}),
		.pin_sync({scl_s, sda_s, strap_hi_s, strap_lo_s})
	);

	// Storage and read port
	sscp_mem #(
		.DEPTH(20)
	) u_mem (
		.mclk(mclk),
		.reset(reset),
		.we(we & byte_done), // Store only on the completing rising edge
		.waddr(we_addr),
		.wdata(rx_byte),
		.raddr(ptr),
		.rdata(rd_data),
		.wr_out(mem_wr),
		.cfg_locked(cfg_locked)
	);

	// Previous samples for edge and condition detection
	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	// Data moving while the clock is high marks start or stop
	assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
	assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;

	assign byte_done = (bus_st == st_rx) && scl_rise && bit_cnt == 4'h7;
	assign rx_byte = {rx_sr[6:0], sda_s};
	assign master_ack = ~sda_s;
	assign tx_byte = send_cnt ? `SSCP_BLK_RD_COUNT : rd_data;
	assign rd_last = blk_rd && !send_cnt && blk_left == 5'h01;

	// Byte decisions by transaction phase
	always_comb begin
		ack_dec = 1'b0;
		go_tx = 1'b0;
		we = 1'b0;
		we_addr = ptr;
		reboot_set = 1'b0;
		arm_set = 1'b0;
		arm_clr = 1'b0;
		ptr_load = 1'b0;
		nptr = ptr;
		cnt_load = 1'b0;
		cnt_dec = 1'b0;
		nphase = ph_ignore;
		case (phase)
			ph_addr: begin
				if (rx_byte[7:4] == `SSCP_DEV_NIBBLE &&
					rx_byte[3:2] == {strap_hi_s, strap_lo_s} &&
					!busy_in) begin
					ack_dec = 1'b1;
					// Bit zero picks direction
					if (rx_byte[0]) begin
						go_tx = 1'b1;
						nphase = ph_rd;
					end else begin
						nphase = ph_cmd;
					end
				end
			end
			ph_cmd: begin
				arm_clr = 1'b1;
				if (rx_byte == `SSCP_CMD_REBOOT) begin
					ack_dec = 1'b1;
					reboot_set = 1'b1;
				end else if (rx_byte == `SSCP_CMD_BLK_WR) begin
					ack_dec = 1'b1;
					nphase = ph_count;
				end else if (rx_byte == `SSCP_CMD_BLK_RD) begin
					ack_dec = 1'b1;
					arm_set = 1'b1;
				end else if (rx_byte == `SSCP_CMD_BLK_WR_SEL) begin
					ack_dec = 1'b1;
				end else if (sscp_valid(rx_byte)) begin
					ack_dec = 1'b1;
					ptr_load = 1'b1;
					nptr = rx_byte;
					nphase = ph_data1;
				end
				// Anything else is refused and the rest ignored
			end
			ph_data1: begin
				ack_dec = 1'b1;
				we = sscp_wr_ok(ptr, cfg_locked);
				nphase = ph_data2;
			end
			ph_data2: begin
				// Second byte goes to the following location
				ack_dec = 1'b1;
				we_addr = sscp_next(ptr);
				we = sscp_wr_ok(we_addr, cfg_locked);
			end
			ph_count: begin
				if (rx_byte != 8'h00 && rx_byte <= {3'h0, `SSCP_BLK_MAX}) begin
					ack_dec = 1'b1;
					cnt_load = 1'b1;
					nphase = ph_blkw;
				end
			end
			ph_blkw: begin
				// Bytes beyond the announced count are refused
				if (blk_left != 5'h00) begin
					ack_dec = 1'b1;
					we = sscp_wr_ok(ptr, cfg_locked);
					ptr_load = 1'b1;
					nptr = sscp_next(ptr);
					cnt_dec = 1'b1;
					nphase = ph_blkw;
				end
			end
			default: begin
				nphase = ph_ignore;
			end
		endcase
	end

	// Bit-level state machine
	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_st <= st_idle;
		end else if (bus_start) begin
			bus_st <= st_rx;
		end else if (bus_stop) begin
			bus_st <= st_idle;
		end else begin
			case (bus_st)
				st_rx: begin
					if (byte_done)
						bus_st <= (ack_dec || phase != ph_addr) ? st_rx_ack
							: st_idle;
				end
				st_rx_ack: begin
					if (scl_fall)
						bus_st <= st_rx_hold;
				end
				st_rx_hold: begin
					if (scl_fall) begin
						if (go_tx_q)
							bus_st <= st_tx;
						else
							bus_st <= ack_q ? st_rx : st_idle;
					end
				end
				st_tx: begin
					if (scl_fall && bit_cnt == 4'h8)
						bus_st <= st_tx_ack;
				end
				st_tx_ack: begin
					// Master refusal or a full block ends sending
					if (scl_rise)
						bus_st <= (master_ack && !rd_last) ? st_tx_next : st_idle;
				end
				st_tx_next: begin
					if (scl_fall)
						bus_st <= st_tx;
				end
				default: begin
					bus_st <= st_idle;
				end
			endcase
		end
	end

	// Bit counter and shift registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			bit_cnt <= 4'h0;
			rx_sr <= 8'h00;
			tx_sr <= 8'h00;
		end else if (bus_start) begin
			bit_cnt <= 4'h0;
		end else if (bus_st == st_rx && scl_rise) begin
			rx_sr <= rx_byte;
			bit_cnt <= bit_cnt + 4'h1;
		end else if (bus_st == st_tx && scl_rise) begin
			bit_cnt <= bit_cnt + 4'h1;
		end else if (bus_st == st_tx && scl_fall && bit_cnt != 4'h8) begin
			tx_sr <= {tx_sr[6:0], 1'b0};
		end else if (scl_fall && ((bus_st == st_rx_hold) ||
			(bus_st == st_tx_next))) begin
			// Load the next outgoing byte as the line is handed over
			bit_cnt <= 4'h0;
			tx_sr <= tx_byte;
		end
	end

	// Acknowledge decision kept until the ninth clock
	always_ff @(posedge mclk) begin
		if (reset) begin
			ack_q <= 1'b0;
			go_tx_q <= 1'b0;
		end else if (byte_done) begin
			ack_q <= ack_dec;
			go_tx_q <= go_tx & ack_dec;
		end
	end

	// Data line driver; changes only while the clock is low
	always_ff @(posedge mclk) begin
		if (reset || bus_start || bus_stop) begin
			sda_drv <= 1'b0;
		end else if (scl_fall) begin
			case (bus_st)
				st_rx_ack: sda_drv <= ack_q;
				st_rx_hold: sda_drv <= go_tx_q & ~tx_byte[7];
				st_tx: sda_drv <= (bit_cnt != 4'h8) & ~tx_sr[6];
				st_tx_next: sda_drv <= ~tx_byte[7];
				default: sda_drv <= 1'b0;
			endcase
		end
	end

	// Transaction phase follows each completed byte
	always_ff @(posedge mclk) begin
		if (reset)
			phase <= ph_addr;
		else if (bus_start)
			phase <= ph_addr;
		else if (byte_done)
			phase <= nphase;
	end

	// Address pointer; a stop does not touch it
	always_ff @(posedge mclk) begin
		if (reset) begin
			ptr <= `SSCP_PTR_RST;
		end else if (byte_done && ptr_load) begin
			ptr <= nptr;
		end else if (bus_st == st_tx_ack && scl_rise && master_ack &&
			!send_cnt) begin
			ptr <= sscp_next(ptr);
		end
	end

	// Block-read arming and remaining byte count
	always_ff @(posedge mclk) begin
		if (reset) begin
			blk_armed <= 1'b0;
			blk_rd <= 1'b0;
			send_cnt <= 1'b0;
			blk_left <= 5'h00;
		end else if (byte_done && phase == ph_addr && ack_dec && rx_byte[0]) begin
			// Block read opens with the count byte
			blk_rd <= blk_armed;
			send_cnt <= blk_armed;
			blk_armed <= 1'b0;
			blk_left <= `SSCP_BLK_MAX;
		end else if (byte_done) begin
			if (arm_set)
				blk_armed <= 1'b1;
			else if (arm_clr)
				blk_armed <= 1'b0;
			if (cnt_load)
				blk_left <= rx_byte[4:0];
			else if (cnt_dec)
				blk_left <= blk_left - 5'h01;
		end else if (bus_st == st_tx_ack && scl_rise && master_ack) begin
			if (send_cnt)
				send_cnt <= 1'b0;
			else if (blk_rd)
				blk_left <= blk_left - 5'h01;
		end
	end

	// One-cycle reboot request
	always_ff @(posedge mclk) begin
		if (reset)
			reboot_pulse <= 1'b0;
		else
			reboot_pulse <= byte_done & reboot_set;
	end

	// Open drain: only a low is ever driven
	always_ff @(posedge mclk) begin
		if (reset)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	assign sda_oe_n = ~sda_drv;

endmodule : sscp_port

// [tb/sscp_port_properties.sv]
// Pin-level checks on the serial command port.
// Assumes binding to sscp_port; one clock, synchronous reset.
`timescale 1ns/1ps
module sscp_port_properties
	import sscp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	// Straps and status
	input wire logic addr_strap_high,
	input wire logic addr_strap_low,
	input wire logic busy_in,
	input wire logic reboot_pulse,
	input wire sscp_wr_t mem_wr,
	input wire logic cfg_locked
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// Store to the lock register, now and one cycle back
	logic w13;
	logic w13_q;
	assign w13 = mem_wr.vld && mem_wr.addr == 8'h13;
	always_ff @(posedge mclk) begin
		w13_q <= w13;
	end

	a_wr_in_window: assert property (mem_wr.vld |-> mem_wr.addr <= 8'h13
		|| (mem_wr.addr >= 8'h20 && mem_wr.addr <= 8'h33))
		else $error("store outside both windows");
	a_wr_one_pulse: assert property (mem_wr.vld |=> !mem_wr.vld)
		else $error("store strobe longer than one cycle");
	a_wr_scl_high: assert property (mem_wr.vld |-> scl_in)
		else $error("store outside a data bit");
	a_reboot_one_pulse: assert property (reboot_pulse |=> !reboot_pulse)
		else $error("reboot strobe longer than one cycle");
	a_stop_release: assert property ($rose(sda_in) && scl_in |-> ##6 sda_oe_n)
		else $error("data line held after stop");
	a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("data drive began while clock high");
	a_lock_source: assert property ($changed(cfg_locked) |-> w13 || w13_q)
		else $error("lock changed without a store to 13h");
	a_lock_blocks: assert property (cfg_locked && mem_wr.vld
		|-> mem_wr.addr == 8'h13 || mem_wr.addr == 8'h33)
		else $error("store while locked");
endmodule : sscp_port_properties

// [tb/sscp_master.sv]
// Behavioural two-wire bus master driving the serial command port.
// Assumes a pull-up on the data line; released means logic high.
`timescale 1ns/1ps
module sscp_master (
	// Clock
	input wire logic mclk,
	// Bus lines
	input wire logic sda,
	output logic scl,
	output logic sda_rel
);
	// Third of a bit time, long against the port's synchroniser
	localparam int H = 8;

	// Bus idle until a task runs
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	task hw;
		repeat (H) @(posedge mclk);
	endtask : hw

	// Data falls while clock high
	task start;
		sda_rel <= 1'b1;
		hw;
		scl <= 1'b1;
		hw;
		sda_rel <= 1'b0;
		hw;
		scl <= 1'b0;
		hw;
	endtask : start

	// Data rises while clock high
	task stop;
		sda_rel <= 1'b0;
		hw;
		scl <= 1'b1;
		hw;
		sda_rel <= 1'b1;
		hw;
	endtask : stop

	// Data changes only while clock low
	task bit_io(input logic b, output logic v);
		sda_rel <= b;
		hw;
		scl <= 1'b1;
		hw;
		v = sda;
		scl <= 1'b0;
		hw;
	endtask : bit_io

	// MSB first, then the slave's acknowledge
	task wbyte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], a);
		end
		bit_io(1'b1, a);
		ack = !a;
	endtask : wbyte

	// A low ninth bit asks for more; high ends the read
	task rbyte(input logic ack, output logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!ack, a);
	endtask : rbyte
endmodule : sscp_master

// [tb/test_sscp_port.sv]
// Self-checking bench for the serial command port.
// Assumes the master model and checker files are compiled before this one.
`timescale 1ns/1ps
module test_sscp_port;
	import sscp_pkg::*;
	logic mclk;
	logic reset;
	logic strap_hi;
	logic strap_lo;
	logic busy;
	logic scl;
	logic sda_rel;
	logic sda_out;
	logic sda_oe_n;
	logic reboot_pulse;
	logic cfg_locked;
	logic a;
	logic [7:0] d;
	sscp_wr_t mem_wr;
	sscp_wr_t wq[$];
	int num_errors = 0;
	int n_tests = 0;
	int n_reboot = 0;
	// Open-drain data line with pull-up
	wire logic sda = sda_rel & (sda_oe_n | sda_out);

	sscp_port dut (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_high(strap_hi),
		.addr_strap_low(strap_lo), .busy_in(busy), .reboot_pulse(reboot_pulse),
		.mem_wr(mem_wr), .cfg_locked(cfg_locked));
	sscp_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Record stores and reboots as they happen
	always @(posedge mclk) begin
		if (mem_wr.vld === 1'b1) wq.push_back(mem_wr);
		if (reboot_pulse === 1'b1) n_reboot++;
	end

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task chk_b(input string n, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask : chk_b

	task chk_v(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_v

	// Oldest recorded store; empty queue reads as zero
	task chk_wr(input logic [7:0] ad, input logic [7:0] dt);
		sscp_wr_t w;
		w = (wq.size() > 0) ? wq.pop_front() : '0;
		chk_v("store addr", ad, w.addr);
		chk_v("store data", dt, w.data);
	endtask : chk_wr

	task put(input logic [7:0] b, input logic e, input string n);
		m.wbyte(b, a);
		chk_b(n, e, a);
	endtask : put

	// Straps are 1 and 0, so write address A8h
	task open_w;
		m.start;
		put(8'hA8, 1'b1, "addr");
	endtask : open_w

	task t_addr;
		logic [7:0] ad[4] = '{8'hA8, 8'hAA, 8'hA0, 8'hB8};
		logic ex[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 4; i++) begin
			m.start;
			put(ad[i], ex[i], "addr match");
			m.stop;
		end
		busy <= 1'b1;
		m.start;
		put(8'hA8, 1'b0, "busy addr");
		m.stop;
		busy <= 1'b0;
		$display("t_addr done");
	endtask : t_addr

	task t_byte;
		open_w;
		put(8'h05, 1'b1, "cmd");
		put(8'h5A, 1'b1, "data1");
		put(8'h3C, 1'b1, "data2");
		m.stop;
		chk_wr(8'h05, 8'h5A);
		chk_wr(8'h06, 8'h3C);
		open_w;
		put(8'h14, 1'b0, "bad cmd");
		put(8'h77, 1'b0, "bad data");
		m.stop;
		open_w;
		put(8'h25, 1'b1, "ee cmd");
		put(8'h99, 1'b1, "ee data");
		m.stop;
		chk_wr(8'h25, 8'h99);
		chk_v("extra stores", 8'h00, 8'(wq.size()));
		open_w;
		put(8'h05, 1'b1, "send byte");
		m.stop;
		m.start;
		put(8'hA9, 1'b1, "read addr");
		m.rbyte(1'b1, d);
		chk_v("read 0", 8'h5A, d);
		m.rbyte(1'b0, d);
		chk_v("read 1", 8'h3C, d);
		m.stop;
		$display("t_byte done");
	endtask : t_byte

	task t_send;
		logic [7:0] c[4] = '{8'h14, 8'h34, 8'hC0, 8'hC1};
		logic ex[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
		for (int i = 0; i < 4; i++) begin
			open_w;
			put(c[i], ex[i], "send code");
			m.stop;
		end
		open_w;
		m.wbyte(8'hC4, a);
		m.stop;
		chk_v("reboots", 8'h01, 8'(n_reboot));
		$display("t_send done");
	endtask : t_send

	task t_blkr;
		open_w;
		put(8'h05, 1'b1, "ptr");
		m.stop;
		open_w;
		put(8'hC1, 1'b1, "blk rd cmd");
		m.start;
		put(8'hA9, 1'b1, "read addr");
		m.rbyte(1'b1, d);
		chk_v("count", 8'h10, d);
		m.rbyte(1'b1, d);
		chk_v("blk 0", 8'h5A, d);
		m.rbyte(1'b0, d);
		chk_v("blk 1", 8'h3C, d);
		m.stop;
		chk_b("released", 1'b1, sda);
		$display("t_blkr done");
	endtask : t_blkr

	task t_blkw;
		open_w;
		put(8'h11, 1'b1, "ptr");
		m.stop;
		open_w;
		put(8'h83, 1'b1, "blk cmd");
		put(8'h04, 1'b1, "count");
		for (int i = 0; i < 4; i++) begin
			put(8'h10 + 8'(i), 1'b1, "blk data");
		end
		put(8'h55, 1'b0, "beyond count");
		m.stop;
		// Pointer saturates at 13h, last two bytes land there
		for (int i = 0; i < 4; i++) begin
			chk_wr(8'(i < 2 ? 17 + i : 19), 8'h10 + 8'(i));
		end
		chk_b("locked", 1'b1, cfg_locked);
		open_w;
		put(8'h83, 1'b1, "blk cmd");
		put(8'h00, 1'b0, "zero count");
		m.stop;
		open_w;
		put(8'h83, 1'b1, "blk cmd");
		put(8'h11, 1'b0, "big count");
		m.stop;
		open_w;
		put(8'h07, 1'b1, "cmd");
		put(8'hEE, 1'b1, "locked data");
		m.stop;
		chk_v("locked stores", 8'h00, 8'(wq.size()));
		open_w;
		put(8'h13, 1'b1, "cmd");
		put(8'h00, 1'b1, "unlock");
		m.stop;
		chk_wr(8'h13, 8'h00);
		chk_b("unlocked", 1'b0, cfg_locked);
		$display("t_blkw done");
	endtask : t_blkw

	// Main sequence
	initial begin
		reset = 1'b1;
		strap_hi = 1'b1;
		strap_lo = 1'b0;
		busy = 1'b0;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		t_addr;
		t_byte;
		t_send;
		t_blkr;
		t_blkw;
		report_and_stop;
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge mclk);
		num_errors++;
		report_and_stop;
	end
endmodule : test_sscp_port

bind sscp_port sscp_port_properties chk (.mclk(mclk), .reset(reset),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .addr_strap_high(addr_strap_high),
	.addr_strap_low(addr_strap_low), .busy_in(busy_in),
	.reboot_pulse(reboot_pulse), .mem_wr(mem_wr), .cfg_locked(cfg_locked));
